// >>> include/bitaddr_map.vh
// Constants for the bit addressing and register bank select block.
`ifndef BITADDR_MAP_VH
`define BITADDR_MAP_VH
// ----------------------------------------
// APB register offsets (byte addresses)
// ----------------------------------------
`define OFF_CTRL       12'h000
`define OFF_REQ        12'h004
`define OFF_RESULT     12'h008
`define OFF_STATUS     12'h00C
`define OFF_SP         12'h010
`define OFF_REGIDX     12'h014
`define OFF_REGDATA    12'h018
// ----------------------------------------
// Request field positions
// ----------------------------------------
`define REQ_OPER_LSB   0
`define REQ_OPER_MSB   11
`define REQ_BIT_LSB    12
`define REQ_BIT_MSB    13
`define REQ_MODE_LSB   16
`define REQ_MODE_MSB   18
`define REQ_OP_LSB     20
`define REQ_OP_MSB     22
// ----------------------------------------
// Addressing modes
// ----------------------------------------
`define MODE_DIRECT    3'h0
`define MODE_FMEM      3'h1
`define MODE_PMEM      3'h2
`define MODE_HMEM      3'h3
`define MODE_PUSH      3'h4
`define MODE_POP       3'h5
// ----------------------------------------
// Bit operations
// ----------------------------------------
`define OP_SET         3'h0
`define OP_CLEAR       3'h1
`define OP_TEST        3'h2
`define OP_AND         3'h3
`define OP_OR          3'h4
`define OP_XOR         3'h5
`define OP_MOVE        3'h6
`define OP_TCLR        3'h7
// ----------------------------------------
// Address windows and fixed locations
// ----------------------------------------
`define FMEM_IO_LO     12'hFF0
`define FMEM_INT_LO    12'hFB0
`define FMEM_INT_HI    12'hFBF
`define PMEM_LO        12'hFC0
`define PSW_ADDR       12'hFB0
`define RBE_BITPOS     2'h0
`define SP_RESET       8'h00
`endif

// >>> verilog/nibble_ram.v
// Nibble-wide data memory with a registered read port.
`timescale 1ns/1ps
module nibble_ram (
   input  wire        core_clk_i,
   input  wire        we_i,
   input  wire [11:0] waddr_i,
   input  wire [3:0]  wdata_i,
   input  wire [11:0] raddr_i,
   output reg  [3:0]  rdata_o
);
   reg [3:0] mem_q [0:4095];

   // One write and one registered read per cycle; no reset on the array.
   always @(posedge core_clk_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_q[raddr_i];
   end
endmodule // nibble_ram

// >>> verilog/bit_addr_bank.v
// Bit address generation, stack addressing and register bank select.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "bitaddr_map.vh"

// Functional notes
// - Plain direct bit mode permits only set, clear and test.
// - Fixed peripheral-bit mode accepts FF0H..FFFH and the FB0H interrupt range.
// - Fixed mode reaches up to FFFH, ignoring memory bank flag and value.
// - L-indexed mode limited to FC0H..FFFH, ignoring memory bank settings.
// - L-indexed: operand gives upper 10 address bits, L the rest.
// - Stepping L reaches 16 bits across four nibbles.
// - H-paged: H gives upper four bits, operand low four, bank from flags.
// - Stack addresses bank 0 at the 8-bit stack pointer.
// - Stack serves push, pop and call, return, interrupt save/restore; here the RAM stack serves push and pop only, and the others use flag_stack_q.
// - Four banks of eight nibble registers at bank 0 00H..1FH.
// - Active register bank is enable flag ANDed with select value.
// - Flag 0 gives bank 0; flag 1 uses select bits 1..0.
// - Register bank enable flag saved on call, restored on return.
// - Interrupt entry saves flag and loads vector value; return restores.
// - Register bank select value can be pushed and popped; push takes request bits 27:24, pop loads the result word.
// - Enable flag written by bit set/clear; select only by select op.
// - Registers usable as nibbles and as 8-bit pairs; a REGDATA read returns one nibble only.
// - L bits 3..2 give low address bits, bits 1..0 the bit.
// - Primed pairs come from the active bank with bit 0 inverted.
module bit_addr_bank (
   input  wire        core_clk_i,
   input  wire        rst_i,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg  [1:0]  active_reg_bank_o,
   output reg  [3:0]  active_mem_bank_o
);
   // ----------------------------------------
   // State and registers
   // ----------------------------------------
   localparam [3:0] ST_IDLE  = 4'b0001;
   localparam [3:0] ST_READ  = 4'b0010;
   localparam [3:0] ST_WRITE = 4'b0100;
   localparam [3:0] ST_DONE  = 4'b1000;

   reg [3:0]  state_q;
   reg        mem_bank_enable_flag_q;
   reg [3:0]  mem_bank_select_value_q;
   reg        reg_bank_enable_flag_q;
   reg [3:0]  reg_bank_select_value_q;
   reg [7:0]  stack_pointer_reg_q;
   reg [3:0]  l_reg_q;
   reg [3:0]  h_reg_q;
   reg        carry_q;
   reg        result_q;
   reg        err_q;
   reg [11:0] addr_q;
   reg [1:0]  bitpos_q;
   reg [2:0]  op_q;
   reg [2:0]  mode_q;
   reg [3:0]  push_data_q;
   reg [4:0]  regidx_q;
   reg [3:0]  regdata_q;
   reg        ram_we;
   reg [11:0] ram_waddr;
   reg [3:0]  ram_wdata;
   reg [11:0] ram_raddr;
   wire [3:0] ram_rdata;

   wire       setup   = psel & ~penable;
   wire       wr_fire = setup & pwrite;
   wire       rd_fire = setup & ~pwrite;

   // ----------------------------------------
   // Shared decode functions
   // ----------------------------------------
   // Bank formed as enable flag ANDed with select value.
   function [3:0] gated_bank;
      input       en;
      input [3:0] sel;
      begin
         gated_bank = en ? sel : 4'h0;
      end
   endfunction

   // Replace one bit of a nibble, leaving the other three as they were.
   function [3:0] put_bit;
      input [3:0] nib;
      input [1:0] pos;
      input       val;
      reg   [3:0] m;
      begin
         m       = 4'h1 << pos;
         put_bit = val ? (nib | m) : (nib & ~m);
      end
   endfunction

   // Register-file nibble address: bank times eight plus register index.
   function [11:0] reg_addr;
      input [1:0] bank;
      input [2:0] idx;
      begin
         reg_addr = {7'h00, bank, idx};
      end
   endfunction

   // Select bits 3..2 always read as zero, so the bank is two bits wide.
   wire [3:0] rb_full  = gated_bank(reg_bank_enable_flag_q, reg_bank_select_value_q);
   wire [1:0] rb       = rb_full[1:0];
   wire [3:0] mb       = gated_bank(mem_bank_enable_flag_q, mem_bank_select_value_q);

   // ----------------------------------------
   // Address generation for a request word
   // ----------------------------------------
   reg [11:0] gen_addr;
   reg [1:0]  gen_bit;
   reg        gen_ok;
   wire [11:0] r_oper = pwdata[`REQ_OPER_MSB:`REQ_OPER_LSB];
   wire [1:0]  r_bit  = pwdata[`REQ_BIT_MSB:`REQ_BIT_LSB];
   wire [2:0]  r_mode = pwdata[`REQ_MODE_MSB:`REQ_MODE_LSB];
   wire [2:0]  r_op   = pwdata[`REQ_OP_MSB:`REQ_OP_LSB];
   wire        r_basic = (r_op == `OP_SET) | (r_op == `OP_CLEAR) | (r_op == `OP_TEST);

   // Combinational address former; the memory bank is used only by direct and H-paged modes.
   always @* begin
      gen_addr = 12'h000;
      gen_bit  = r_bit;
      gen_ok   = 1'b0;
      case (r_mode)
         `MODE_DIRECT: begin
            gen_addr = {mb, r_oper[7:0]};
            gen_ok   = r_basic;
         end
         `MODE_FMEM: begin
            gen_addr = r_oper;
            gen_ok   = (r_oper >= `FMEM_IO_LO) |
                       ((r_oper >= `FMEM_INT_LO) & (r_oper <= `FMEM_INT_HI));
         end
         `MODE_PMEM: begin
            gen_addr = {r_oper[11:2], l_reg_q[3:2]};
            gen_bit  = l_reg_q[1:0];
            gen_ok   = (r_oper >= `PMEM_LO);
         end
         `MODE_HMEM: begin
            gen_addr = {mb, h_reg_q, r_oper[3:0]};
            gen_ok   = 1'b1;
         end
         `MODE_PUSH: begin
            gen_addr = {4'h0, stack_pointer_reg_q - 8'h01};
            gen_ok   = 1'b1;
         end
         `MODE_POP: begin
            gen_addr = {4'h0, stack_pointer_reg_q};
            gen_ok   = 1'b1;
         end
         default: begin
            gen_ok = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Memory port steering
   // ----------------------------------------
   // Read-modify-write: the nibble is read in ST_READ and written in ST_WRITE.
   always @* begin
      ram_we    = 1'b0;
      ram_waddr = addr_q;
      ram_wdata = 4'h0;
      ram_raddr = addr_q;
      if (state_q == ST_WRITE) begin
         if (mode_q == `MODE_PUSH) begin
            ram_we    = 1'b1;
            ram_wdata = push_data_q;
         end else if ((mode_q != `MODE_POP) && (op_q != `OP_TEST) &&
                      (op_q != `OP_AND) && (op_q != `OP_OR) && (op_q != `OP_XOR)) begin
            ram_we = 1'b1;
            case (op_q)
               `OP_SET:   ram_wdata = put_bit(ram_rdata, bitpos_q, 1'b1);
               `OP_MOVE:  ram_wdata = put_bit(ram_rdata, bitpos_q, carry_q);
               default:   ram_wdata = put_bit(ram_rdata, bitpos_q, 1'b0);
            endcase
         end
      end else if (rd_fire && (paddr == `OFF_REGDATA)) begin
         ram_raddr = reg_addr(regidx_q[4:3] ^ rb, regidx_q[2:0]);
      end
   end

   nibble_ram u_ram (
      .core_clk_i (core_clk_i),
      .we_i       (ram_we),
      .waddr_i    (ram_waddr),
      .wdata_i    (ram_wdata),
      .raddr_i    (ram_raddr),
      .rdata_o    (ram_rdata)
   );

   // ----------------------------------------
   // Sequencer and software-visible state
   // ----------------------------------------
   // Control word bits: 0 mem enable, 7:4 mem select, 8 reg enable set/clear
   // strobe pair (9 set, 10 clear), 13:12 reg select, 14 call, 15 return,
   // 16 irq entry, 17 irq return, 18 vector flag, 23:20 H, 27:24 L, 28 carry.
   reg [15:0] flag_stack_q;  // saved enable flags, one per nesting level
   wire       ctrl_wr = wr_fire && (paddr == `OFF_CTRL) && (state_q == ST_IDLE);

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q                 <= ST_IDLE;
         mem_bank_enable_flag_q  <= 1'b0;
         mem_bank_select_value_q <= 4'h0;
         reg_bank_enable_flag_q  <= 1'b0;
         reg_bank_select_value_q <= 4'h0;
         stack_pointer_reg_q     <= `SP_RESET;
         l_reg_q                 <= 4'h0;
         h_reg_q                 <= 4'h0;
         carry_q                 <= 1'b0;
         result_q                <= 1'b0;
         err_q                   <= 1'b0;
         addr_q                  <= 12'h000;
         bitpos_q                <= 2'h0;
         op_q                    <= 3'h0;
         mode_q                  <= 3'h0;
         push_data_q             <= 4'h0;
         regidx_q                <= 5'h00;
         regdata_q               <= 4'h0;
         flag_stack_q            <= 16'h0000;
         pready                  <= 1'b0;
         pslverr                 <= 1'b0;
         prdata                  <= 32'h0000_0000;
         active_reg_bank_o       <= 2'h0;
         active_mem_bank_o       <= 4'h0;
      end else begin
         pready            <= 1'b0;
         pslverr           <= 1'b0;
         active_reg_bank_o <= rb;
         active_mem_bank_o <= mb;
         case (state_q)
            ST_IDLE: begin
               if (ctrl_wr) begin
                  mem_bank_enable_flag_q  <= pwdata[0];
                  mem_bank_select_value_q <= pwdata[7:4];
                  h_reg_q                 <= pwdata[23:20];
                  l_reg_q                 <= pwdata[27:24];
                  carry_q                 <= pwdata[28];
                  if (pwdata[9]) begin
                     reg_bank_enable_flag_q <= 1'b1;
                  end else if (pwdata[10]) begin
                     reg_bank_enable_flag_q <= 1'b0;
                  end
                  if (pwdata[11]) begin
                     reg_bank_select_value_q <= {2'b00, pwdata[13:12]};
                  end
                  if (pwdata[14]) begin
                     flag_stack_q <= {flag_stack_q[14:0], reg_bank_enable_flag_q};
                  end else if (pwdata[15] | pwdata[17]) begin
                     reg_bank_enable_flag_q <= flag_stack_q[0];
                     flag_stack_q           <= {1'b0, flag_stack_q[15:1]};
                  end else if (pwdata[16]) begin
                     flag_stack_q <= {flag_stack_q[14:0], reg_bank_enable_flag_q};
                     reg_bank_enable_flag_q <= pwdata[18];
                  end
                  pready <= 1'b1;
               end else if (wr_fire && (paddr == `OFF_REQ)) begin
                  if (gen_ok) begin
                     addr_q      <= gen_addr;
                     bitpos_q    <= gen_bit;
                     op_q        <= r_op;
                     mode_q      <= r_mode;
                     push_data_q <= pwdata[27:24];
                     err_q       <= 1'b0;
                     state_q     <= (r_mode == `MODE_PUSH) ? ST_WRITE : ST_READ;
                     if (r_mode == `MODE_PUSH) begin
                        stack_pointer_reg_q <= stack_pointer_reg_q - 8'h01;
                     end
                  end else begin
                     err_q   <= 1'b1;
                     pready  <= 1'b1;
                     pslverr <= 1'b1;
                  end
               end else if (wr_fire && (paddr == `OFF_SP)) begin
                  stack_pointer_reg_q <= pwdata[7:0];
                  pready              <= 1'b1;
               end else if (wr_fire && (paddr == `OFF_REGIDX)) begin
                  regidx_q <= pwdata[4:0];
                  pready   <= 1'b1;
               end else if (wr_fire) begin
                  pready  <= 1'b1;
                  pslverr <= (paddr != `OFF_RESULT) && (paddr != `OFF_STATUS) &&
                             (paddr != `OFF_REGDATA);
               end else if (rd_fire && (paddr == `OFF_REGDATA)) begin
                  state_q <= ST_DONE; // wait for the registered RAM read
               end else if (rd_fire) begin
                  pready <= 1'b1;
                  case (paddr)
                     `OFF_CTRL:   prdata <= {3'h0, carry_q, l_reg_q, h_reg_q, 6'h00,
                                             reg_bank_select_value_q[1:0], 1'b0,
                                             1'b0, 1'b0, reg_bank_enable_flag_q,
                                             mem_bank_select_value_q, 3'h0,
                                             mem_bank_enable_flag_q};
                     `OFF_RESULT: prdata <= {27'h0, regdata_q, result_q};
                     `OFF_STATUS: prdata <= {25'h0, err_q, rb, mb};
                     `OFF_SP:     prdata <= {24'h0, stack_pointer_reg_q};
                     `OFF_REGIDX: prdata <= {27'h00, regidx_q};
                     default: begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b1;
                     end
                  endcase
               end
            end
            ST_READ: begin
               state_q <= ST_WRITE;
            end
            ST_WRITE: begin
               state_q <= ST_IDLE;
               pready  <= 1'b1;
               if (mode_q == `MODE_POP) begin
                  regdata_q           <= ram_rdata;
                  stack_pointer_reg_q <= stack_pointer_reg_q + 8'h01;
               end else if (mode_q != `MODE_PUSH) begin
                  result_q <= ram_rdata[bitpos_q];
                  case (op_q)
                     `OP_AND:  carry_q <= carry_q & ram_rdata[bitpos_q];
                     `OP_OR:   carry_q <= carry_q | ram_rdata[bitpos_q];
                     `OP_XOR:  carry_q <= carry_q ^ ram_rdata[bitpos_q];
                     default:  carry_q <= carry_q;
                  endcase
                  // The enable flag lives at a fixed peripheral bit too.
                  if ((addr_q == `PSW_ADDR) && (bitpos_q == `RBE_BITPOS)) begin
                     if (op_q == `OP_SET) begin
                        reg_bank_enable_flag_q <= 1'b1;
                     end else if ((op_q == `OP_CLEAR) || (op_q == `OP_TCLR)) begin
                        reg_bank_enable_flag_q <= 1'b0;
                     end
                  end
               end
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
               pready  <= 1'b1;
               prdata  <= {28'h0000_000, ram_rdata};
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // bit_addr_bank

// >>> sim/bit_addr_bank_sva.sv
// Bus timing and bank output checks for the bit address block.
`timescale 1ns/1ps
`include "bitaddr_map.vh"
module bit_addr_bank_sva (
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [1:0]  active_reg_bank_o,
   input wire logic [3:0]  active_mem_bank_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // Phases of one bus transfer.
   sequence setup_s; psel && !penable; endsequence
   sequence done_s; psel && penable && pready; endsequence

   // A completed write is the only thing that may move a bank output.
   wire wr_done = psel && penable && pready && pwrite;

   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held high");
   ready_phase_a: assert property (pready |-> psel && penable) else $error("ready outside access");
   answer_bound_a: assert property (setup_s |-> ##[1:3] done_s) else $error("answer too late");
   status_fast_a: assert property (setup_s ##0 (paddr == `OFF_STATUS) |-> ##1 pready)
      else $error("status answer late");
   err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   unmapped_read_a: assert property (done_s ##0 (!pwrite && paddr > `OFF_REGDATA)
      |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped read accepted");
   ctrl_ok_a: assert property (done_s ##0 (paddr == `OFF_CTRL) |-> !pslverr)
      else $error("control access refused");
   direct_refuse_a: assert property (done_s ##0 (pwrite && paddr == `OFF_REQ &&
      pwdata[`REQ_MODE_MSB:`REQ_MODE_LSB] == `MODE_DIRECT &&
      pwdata[`REQ_OP_MSB:`REQ_OP_LSB] >= `OP_AND) |-> pslverr)
      else $error("direct mode took a wide bit operation");
   reg_bank_cause_a: assert property ($changed(active_reg_bank_o) |->
      $past(wr_done) || $past(wr_done, 2)) else $error("register bank moved alone");
   mem_bank_cause_a: assert property ($changed(active_mem_bank_o) |->
      $past(wr_done) || $past(wr_done, 2)) else $error("memory bank moved alone");
endmodule // bit_addr_bank_sva

bind bit_addr_bank bit_addr_bank_sva u_bit_addr_bank_sva (.core_clk_i(core_clk_i),
   .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .active_reg_bank_o(active_reg_bank_o), .active_mem_bank_o(active_mem_bank_o));

// >>> sim/testbench.sv
// Self-checking bench for the bit address and register bank block.
`timescale 1ns/1ps
`include "bitaddr_map.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); end end
module testbench;
   logic        core_clk_i, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, sp0;
   logic        pready, pslverr, err, mem_en = 1'b0;
   logic [1:0]  active_reg_bank_o;
   logic [3:0]  active_mem_bank_o, mem_sel = 4'h0, hreg = 4'h0, lreg = 4'h0;
   logic [11:0] bad [4] = '{12'hFAF, 12'hFC0, 12'hFEF, 12'h0F0};
   logic [3:0]  pv [2] = '{4'hA, 4'h5};
   int          n_mismatch = 0, check_count = 0;

   bit_addr_bank u_bit_addr_bank (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .active_reg_bank_o(active_reg_bank_o),
      .active_mem_bank_o(active_mem_bank_o));

   // Core clock, 8 ns period.
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // One bus transfer; the request holds until ready is seen at an edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      @(posedge core_clk_i);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge core_clk_i);
         n++;
      end
      if (n >= 20) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: no ready from the block", $time);
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk_i);
   endtask

   // Control write that keeps the bench's copy of the stored fields.
   task automatic ctl(input logic [31:0] cmd);
      apb(1'b1, `OFF_CTRL, cmd | {4'h0, lreg, hreg, 12'h000, mem_sel, 3'b000, mem_en});
   endtask

   task automatic req(input logic [2:0] mode, op, input logic [11:0] oper,
                      input logic [1:0] b, input logic [3:0] pd);
      apb(1'b1, `OFF_REQ, {4'h0, pd, 1'b0, op, 1'b0, mode, 2'b00, b, oper});
   endtask

   // Status fields and bank outputs must agree with the expected banks.
   task automatic stat(input logic [3:0] mb, input logic [1:0] rb);
      apb(1'b0, `OFF_STATUS, 32'h0000_0000);
      `CHK(rd[5:0], {rb, mb})
      `CHK({active_reg_bank_o, active_mem_bank_o}, {rb, mb})
   endtask

   task automatic tst(input logic [2:0] mode, input logic [11:0] oper, input logic [1:0] b,
                      input logic e);
      req(mode, `OP_TEST, oper, b, 4'h0);
      apb(1'b0, `OFF_RESULT, 32'h0000_0000);
      `CHK(rd[0], e)
   endtask

   task automatic rdreg(input logic [31:0] idx, input logic e);
      apb(1'b1, `OFF_REGIDX, idx);
      apb(1'b0, `OFF_REGDATA, 32'h0000_0000);
      `CHK(rd[0], e)
   endtask

   // Main sequence.
   initial begin
      repeat (20) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      stat(4'h0, 2'd0);
      apb(1'b0, `OFF_CTRL, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      $display("test reset done");
      for (int s = 0; s < 4; s++) begin
         ctl(32'h0000_0800 | (32'(s) << 12));
         stat(4'h0, 2'd0);
         ctl(32'h0000_0200);
         stat(4'h0, 2'(s));
         ctl(32'h0000_0400);
      end
      ctl(32'h0000_1200);
      stat(4'h0, 2'd3);
      ctl(32'h0000_4000);
      ctl(32'h0000_0400);
      stat(4'h0, 2'd0);
      ctl(32'h0000_8000);
      stat(4'h0, 2'd3);
      ctl(32'h0001_0000);
      stat(4'h0, 2'd0);
      ctl(32'h0002_0000);
      stat(4'h0, 2'd3);
      req(`MODE_FMEM, `OP_CLEAR, 12'hFB0, 2'd0, 4'h0);
      stat(4'h0, 2'd0);
      ctl(32'h0005_0000);
      stat(4'h0, 2'd3);
      ctl(32'h0002_0000);
      stat(4'h0, 2'd0);
      req(`MODE_FMEM, `OP_SET, 12'hFB0, 2'd0, 4'h0);
      stat(4'h0, 2'd3);
      $display("test register bank done");
      mem_en = 1'b1;
      for (int s = 0; s < 16; s += 5) begin
         mem_sel = 4'(s);
         ctl(32'h0000_0000);
         stat(4'(s), 2'd3);
      end
      mem_en = 1'b0;
      ctl(32'h0000_0000);
      stat(4'h0, 2'd3);
      $display("test memory bank done");
      // Bank set to 7 so that any use of it would misplace the fixed bits.
      mem_en = 1'b1;
      mem_sel = 4'h7;
      ctl(32'h0000_0000);
      for (int b = 0; b < 4; b++) req(`MODE_FMEM, `OP_CLEAR, 12'hFF5, 2'(b), 4'h0);
      req(`MODE_FMEM, `OP_SET, 12'hFF5, 2'd2, 4'h0);
      tst(`MODE_FMEM, 12'hFF5, 2'd2, 1'b1);
      tst(`MODE_FMEM, 12'hFF5, 2'd1, 1'b0);
      tst(`MODE_FMEM, 12'hFF5, 2'd3, 1'b0);
      req(`MODE_FMEM, `OP_SET, 12'hFBF, 2'd3, 4'h0);
      tst(`MODE_FMEM, 12'hFBF, 2'd3, 1'b1);
      for (int o = 3; o < 6; o++) begin
         req(`MODE_FMEM, 3'(o), 12'hFF5, 2'd2, 4'h0);
         `CHK(err, 1'b0)
      end
      req(`MODE_FMEM, `OP_TCLR, 12'hFF5, 2'd2, 4'h0);
      apb(1'b0, `OFF_RESULT, 32'h0000_0000);
      `CHK(rd[0], 1'b1)
      tst(`MODE_FMEM, 12'hFF5, 2'd2, 1'b0);
      // Carry set to one, moved into a bit, then cleared by an AND with a zero bit.
      ctl(32'h1000_0000);
      req(`MODE_FMEM, `OP_MOVE, 12'hFF5, 2'd1, 4'h0);
      tst(`MODE_FMEM, 12'hFF5, 2'd1, 1'b1);
      req(`MODE_FMEM, `OP_AND, 12'hFF5, 2'd3, 4'h0);
      req(`MODE_FMEM, `OP_MOVE, 12'hFF5, 2'd1, 4'h0);
      tst(`MODE_FMEM, 12'hFF5, 2'd1, 1'b0);
      for (int o = 3; o < 8; o++) begin
         req(`MODE_DIRECT, 3'(o), 12'h040, 2'd0, 4'h0);
         `CHK(err, 1'b1)
      end
      req(`MODE_DIRECT, `OP_SET, 12'h040, 2'd0, 4'h0);
      `CHK(err, 1'b0)
      foreach (bad[i]) begin
         req(`MODE_FMEM, `OP_SET, bad[i], 2'd0, 4'h0);
         `CHK(err, 1'b1)
      end
      apb(1'b0, `OFF_STATUS, 32'h0000_0000);
      `CHK(rd[6], 1'b1)
      $display("test fixed bits done");
      for (int k = 0; k < 16; k++) begin
         lreg = 4'(k);
         ctl(32'h0000_0000);
         req(`MODE_PMEM, (k[0] ^ k[3]) ? `OP_SET : `OP_CLEAR, 12'hFF0, 2'd0, 4'h0);
      end
      for (int k = 0; k < 16; k++)
         tst(`MODE_FMEM, 12'hFF0 + 12'(k >> 2), 2'(k), 1'(k[0] ^ k[3]));
      req(`MODE_PMEM, `OP_SET, 12'hFB0, 2'd0, 4'h0);
      `CHK(err, 1'b1)
      $display("test indexed bits done");
      mem_en = 1'b0;
      hreg = 4'h3;
      ctl(32'h0000_0000);
      req(`MODE_DIRECT, `OP_CLEAR, 12'h032, 2'd1, 4'h0);
      mem_en = 1'b1;
      mem_sel = 4'h2;
      ctl(32'h0000_0000);
      req(`MODE_HMEM, `OP_SET, 12'h002, 2'd1, 4'h0);
      tst(`MODE_DIRECT, 12'h032, 2'd1, 1'b1);
      mem_en = 1'b0;
      ctl(32'h0000_0000);
      tst(`MODE_HMEM, 12'h002, 2'd1, 1'b0);
      $display("test paged bits done");
      hreg = 4'h1;
      ctl(32'h0000_0000);
      req(`MODE_HMEM, `OP_SET, 12'h00A, 2'd0, 4'h0);
      req(`MODE_HMEM, `OP_CLEAR, 12'h002, 2'd0, 4'h0);
      ctl(32'h0000_2800);
      rdreg(32'h0000_000A, 1'b1);
      rdreg(32'h0000_0002, 1'b0);
      $display("test register file done");
      apb(1'b0, `OFF_SP, 32'h0000_0000);
      sp0 = rd;
      foreach (pv[i]) req(`MODE_PUSH, `OP_SET, 12'h000, 2'd0, pv[i]);
      for (int i = 1; i >= 0; i--) begin
         req(`MODE_POP, `OP_SET, 12'h000, 2'd0, 4'h0);
         apb(1'b0, `OFF_RESULT, 32'h0000_0000);
         `CHK(rd[4:1], pv[i])
      end
      apb(1'b0, `OFF_SP, 32'h0000_0000);
      `CHK(rd, sp0)
      apb(1'b0, 12'h01C, 32'h0000_0000);
      `CHK({err, rd}, {1'b1, 32'h0000_0000})
      apb(1'b1, 12'h020, 32'hFFFF_FFFF);
      `CHK(err, 1'b1)
      $display("test stack and map done");
      print_verdict();
   end
endmodule // testbench
